// File: reg_conv_pkg.sv
package reg_conv_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int DBG_W = 2;
	localparam int STAT_W = 4;
	localparam int STATE_W = 3;

	// Register indices on the access port.
	localparam logic [ADDR_W-1:0] IDX_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] IDX_STATUS = 3'h1;
	localparam logic [ADDR_W-1:0] IDX_CMD = 3'h2;
	localparam logic [ADDR_W-1:0] IDX_FLAG_CLR = 3'h3;
	localparam logic [ADDR_W-1:0] IDX_FLAG_SET = 3'h4;
	localparam logic [ADDR_W-1:0] IDX_DEBUG = 3'h5;

	// Bits that are implemented; every other position is reserved.
	localparam logic [DATA_W-1:0] CTRL_MASK = 8'h7F;
	localparam logic [DATA_W-1:0] STATUS_MASK = 8'h7F;
	localparam logic [DATA_W-1:0] CMD_MASK = 8'h0F;
	localparam logic [DATA_W-1:0] FLAG_MASK = 8'h7F;
	localparam logic [DATA_W-1:0] DEBUG_MASK = 8'h03;

	// Reset values.
	localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
	localparam logic [DATA_W-1:0] CMD_RST = 8'h00;
	localparam logic [DATA_W-1:0] FLAG_RST = 8'h00;
	localparam logic [DBG_W-1:0] DEBUG_RST = 2'h0;
	localparam logic [DATA_W-1:0] RD_RST = 8'h00;

	// Field positions, upper index first.
	localparam int STAT_FLD_MSB = 3;
	localparam int STAT_FLD_LSB = 0;
	localparam int STATE_FLD_MSB = 6;
	localparam int STATE_FLD_LSB = 4;
	localparam int DBG_FLD_MSB = 1;
	localparam int DBG_FLD_LSB = 0;

	// Legal encodings of the read-only state field; codes above are reserved.
	localparam logic [STATE_W-1:0] STATE_LAST_LEGAL = 3'h4;
	localparam logic [STATE_W-1:0] STATE_FALLBACK = 3'h0;

	localparam logic [DATA_W-1:0] ZERO_WORD = 8'h00;

endpackage : reg_conv_pkg

// File: paired_bit_modify_registers_pair.sv
`timescale 1ns/1ps

module paired_bit_modify_registers_pair #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RST_VAL = '0,
	parameter logic [WIDTH-1:0] MASK = '1
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic soft_rst,
	input wire logic set_we,
	input wire logic [WIDTH-1:0] set_data,
	input wire logic clr_we,
	input wire logic [WIDTH-1:0] clr_data,
	output logic [WIDTH-1:0] state
);

	logic [WIDTH-1:0] state_reg;
	logic [WIDTH-1:0] state_next;
	wire [WIDTH-1:0] set_bits = set_we ? set_data : '0;
	wire [WIDTH-1:0] clr_bits = clr_we ? clr_data : '0;

	// Ones set, ones clear, zeros leave the bit alone.
	// The clear term is applied last so it wins a collision.
	assign state_next = soft_rst ? RST_VAL :
		((state_reg | set_bits) & ~clr_bits & MASK);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= RST_VAL;
		end else begin
			state_reg <= state_next;
		end
	end

	// One shared state is seen through both members.
	assign state = state_reg;

endmodule : paired_bit_modify_registers_pair

// File: reg_bank.sv
`timescale 1ns/1ps

// How it works
// - A read/write bit reads back what was last written to it.
// - A read-only bit shows live hardware state and ignores writes.
// - A write-only bit takes writes but its read value carries no meaning.
// - Every reserved bit position reads as zero whatever was written.
// - A read-only multi-bit field never shows a reserved encoding.
// - Power reset puts every register at its reset value.
// - Soft reset acts like power reset except on the debug, status and read data registers, which it leaves alone.
// - A one written to the clear member clears the shared bit.
// - A one written to the set member sets the shared bit.
// - Both members of a set/clear pair read the same shared value.
// - A set and a clear of one bit in the same cycle leaves it clear.
// - A field n:m is the contiguous bits n down to m, n most significant.
module reg_bank (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic soft_reset,
	input wire logic wr0_en,
	input wire logic [reg_conv_pkg::ADDR_W-1:0] wr0_addr,
	input wire logic [reg_conv_pkg::DATA_W-1:0] wr0_data,
	input wire logic wr1_en,
	input wire logic [reg_conv_pkg::ADDR_W-1:0] wr1_addr,
	input wire logic [reg_conv_pkg::DATA_W-1:0] wr1_data,
	input wire logic rd_en,
	input wire logic [reg_conv_pkg::ADDR_W-1:0] rd_addr,
	input wire logic [reg_conv_pkg::STAT_W-1:0] hw_status,
	input wire logic [reg_conv_pkg::STATE_W-1:0] hw_state,
	output logic [reg_conv_pkg::DATA_W-1:0] rd_data,
	output logic rd_valid,
	output logic [reg_conv_pkg::DATA_W-1:0] ctrl_out,
	output logic [reg_conv_pkg::DATA_W-1:0] flags_out,
	output logic [reg_conv_pkg::DBG_W-1:0] debug_out,
	output logic [reg_conv_pkg::DATA_W-1:0] cmd_out,
	output logic cmd_strobe
);

	import reg_conv_pkg::*;

	logic [DATA_W-1:0] ctrl_reg;
	logic [DATA_W-1:0] ctrl_next;
	logic [DATA_W-1:0] status_reg;
	logic [DATA_W-1:0] status_next;
	logic [DATA_W-1:0] cmd_reg;
	logic [DATA_W-1:0] cmd_next;
	logic cmd_strobe_reg;
	logic cmd_strobe_next;
	logic [DBG_W-1:0] debug_reg;
	logic [DBG_W-1:0] debug_next;
	logic [DATA_W-1:0] rd_data_reg;
	logic [DATA_W-1:0] rd_data_next;
	logic rd_valid_reg;
	logic [DATA_W-1:0] flag_state;

	// Address decode of both write ports.
	wire wr0_ctrl = wr0_en && (wr0_addr == IDX_CTRL);
	wire wr1_ctrl = wr1_en && (wr1_addr == IDX_CTRL);
	wire wr0_cmd = wr0_en && (wr0_addr == IDX_CMD);
	wire wr1_cmd = wr1_en && (wr1_addr == IDX_CMD);
	wire wr0_dbg = wr0_en && (wr0_addr == IDX_DEBUG);
	wire wr1_dbg = wr1_en && (wr1_addr == IDX_DEBUG);
	wire wr0_set = wr0_en && (wr0_addr == IDX_FLAG_SET);
	wire wr1_set = wr1_en && (wr1_addr == IDX_FLAG_SET);
	wire wr0_clr = wr0_en && (wr0_addr == IDX_FLAG_CLR);
	wire wr1_clr = wr1_en && (wr1_addr == IDX_FLAG_CLR);

	// Both ports may hit one member; their ones are merged.
	wire flag_set_we = wr0_set || wr1_set;
	wire flag_clr_we = wr0_clr || wr1_clr;
	wire [DATA_W-1:0] flag_set_data =
		(wr0_set ? wr0_data : ZERO_WORD) | (wr1_set ? wr1_data : ZERO_WORD);
	wire [DATA_W-1:0] flag_clr_data =
		(wr0_clr ? wr0_data : ZERO_WORD) | (wr1_clr ? wr1_data : ZERO_WORD);

	// Port 1 wins when both ports write the same plain register.
	wire [DATA_W-1:0] ctrl_wdata = wr1_ctrl ? wr1_data : wr0_data;
	wire [DATA_W-1:0] cmd_wdata = wr1_cmd ? wr1_data : wr0_data;
	wire [DATA_W-1:0] dbg_wdata = wr1_dbg ? wr1_data : wr0_data;
	wire ctrl_we = wr0_ctrl || wr1_ctrl;
	wire cmd_we = wr0_cmd || wr1_cmd;
	wire dbg_we = wr0_dbg || wr1_dbg;

	// Control register stores writes with reserved bits forced low.
	assign ctrl_next = soft_reset ? CTRL_RST :
		(ctrl_we ? (ctrl_wdata & CTRL_MASK) : ctrl_reg);

	// Reserved state codes are replaced by a legal one.
	wire state_legal = (hw_state <= STATE_LAST_LEGAL);
	wire [STATE_W-1:0] state_shown =
		state_legal ? hw_state : STATE_FALLBACK;

	// Status follows hardware only; no write port reaches it.
	always_comb begin
		status_next = ZERO_WORD;
		status_next[STAT_FLD_MSB:STAT_FLD_LSB] = hw_status;
		status_next[STATE_FLD_MSB:STATE_FLD_LSB] = state_shown;
		status_next = status_next & STATUS_MASK;
	end

	// Command register is write-only and emits a one-cycle strobe.
	assign cmd_next = soft_reset ? CMD_RST :
		(cmd_we ? (cmd_wdata & CMD_MASK) : cmd_reg);
	assign cmd_strobe_next = cmd_we && !soft_reset;

	// Debug control survives a soft reset.
	assign debug_next = dbg_we ?
		dbg_wdata[DBG_FLD_MSB:DBG_FLD_LSB] : debug_reg;

	paired_bit_modify_registers_pair #(
		.WIDTH(DATA_W),
		.RST_VAL(FLAG_RST),
		.MASK(FLAG_MASK)
	) u_flags (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.soft_rst(soft_reset),
		.set_we(flag_set_we),
		.set_data(flag_set_data),
		.clr_we(flag_clr_we),
		.clr_data(flag_clr_data),
		.state(flag_state)
	);

	// Read selection; write-only and unmapped addresses read zero.
	wire [DATA_W-1:0] debug_word = {{(DATA_W-DBG_W){1'b0}}, debug_reg};
	wire rd_is_flag = (rd_addr == IDX_FLAG_SET) || (rd_addr == IDX_FLAG_CLR);
	assign rd_data_next =
		!rd_en ? rd_data_reg :
		(rd_addr == IDX_CTRL) ? ctrl_reg :
		(rd_addr == IDX_STATUS) ? status_reg :
		rd_is_flag ? (flag_state & FLAG_MASK) :
		(rd_addr == IDX_DEBUG) ? (debug_word & DEBUG_MASK) :
		ZERO_WORD;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= CTRL_RST;
			status_reg <= ZERO_WORD;
			cmd_reg <= CMD_RST;
			cmd_strobe_reg <= 1'b0;
			debug_reg <= DEBUG_RST;
		end else begin
			ctrl_reg <= ctrl_next;
			status_reg <= status_next;
			cmd_reg <= cmd_next;
			cmd_strobe_reg <= cmd_strobe_next;
			debug_reg <= debug_next;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_reg <= RD_RST;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_en;
		end
	end

	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;
	assign ctrl_out = ctrl_reg;
	assign flags_out = flag_state;
	assign debug_out = debug_reg;
	assign cmd_out = cmd_reg;
	assign cmd_strobe = cmd_strobe_reg;

endmodule : reg_bank

// File: reg_bank_chk.sv
`timescale 1ns/1ps
module reg_bank_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic soft_reset,
	input wire logic wr0_en,
	input wire logic [2:0] wr0_addr,
	input wire logic [7:0] wr0_data,
	input wire logic wr1_en,
	input wire logic [2:0] wr1_addr,
	input wire logic [7:0] wr1_data,
	input wire logic rd_en,
	input wire logic [2:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic [7:0] ctrl_out,
	input wire logic [7:0] flags_out,
	input wire logic [1:0] debug_out,
	input wire logic [7:0] cmd_out
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	read_answer_a: assert property (rd_en |=> rd_valid)
		else $error("read not answered");
	ctrl_write_a: assert property (wr0_en && wr0_addr == 3'h0 && !wr1_en
		&& !soft_reset |=> ctrl_out == ($past(wr0_data) & 8'h7F))
		else $error("ctrl write lost");
	reserved_zero_a: assert property (!ctrl_out[7] && !flags_out[7]
		&& cmd_out[7:4] == 4'h0) else $error("reserved bit set");
	state_legal_a: assert property (rd_en && rd_addr == 3'h1
		|=> !rd_data[7] && rd_data[6:4] <= 3'h4) else $error("bad state");
	wo_read_a: assert property (rd_en && rd_addr == 3'h2 |=> rd_data == 0)
		else $error("write-only read not zero");
	soft_clear_a: assert property (soft_reset |=> ctrl_out == 0
		&& flags_out == 0 && cmd_out == 0) else $error("soft reset missed");
	debug_keep_a: assert property (soft_reset && !wr0_en && !wr1_en
		|=> $stable(debug_out)) else $error("debug lost");
	clear_wins_a: assert property (wr1_en && wr1_addr == 3'h3
		|=> (flags_out & $past(wr1_data)) == 0) else $error("clear lost");
	cover property (wr0_en && wr1_en && wr0_addr == 3'h4 && wr1_addr == 3'h3);
	cover property (soft_reset);
	cover property (rd_en && rd_addr == 3'h1);
endmodule : reg_bank_chk
bind reg_bank reg_bank_chk reg_bank_chk_i (.core_clk, .reset_n, .soft_reset,
	.wr0_en, .wr0_addr, .wr0_data, .wr1_en, .wr1_addr, .wr1_data, .rd_en,
	.rd_addr, .rd_data, .rd_valid, .ctrl_out, .flags_out, .debug_out, .cmd_out);

// File: test_reg_bank.sv
`timescale 1ns/1ps
module test_reg_bank;
	import reg_conv_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic soft_reset = 1'b0;
	logic wr0_en = 1'b0;
	logic wr1_en = 1'b0;
	logic rd_en = 1'b0;
	logic [2:0] wr0_addr = 3'h0;
	logic [2:0] wr1_addr = 3'h0;
	logic [2:0] rd_addr = 3'h0;
	logic [7:0] wr0_data = 8'h00;
	logic [7:0] wr1_data = 8'h00;
	logic [3:0] hw_status = 4'h0;
	logic [2:0] hw_state = 3'h0;
	logic [7:0] rd_data;
	logic [7:0] ctrl_out;
	logic [7:0] flags_out;
	logic [7:0] cmd_out;
	logic [1:0] debug_out;
	logic rd_valid;
	logic cmd_strobe;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	always #10 core_clk = ~core_clk;
	reg_bank reg_bank_i (.core_clk, .reset_n, .soft_reset, .wr0_en, .wr0_addr,
		.wr0_data, .wr1_en, .wr1_addr, .wr1_data, .rd_en, .rd_addr, .hw_status,
		.hw_state, .rd_data, .rd_valid, .ctrl_out, .flags_out, .debug_out,
		.cmd_out, .cmd_strobe);
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [2:0] a0, input logic [7:0] d0, input logic e1,
		input logic [2:0] a1, input logic [7:0] d1);
		@(negedge core_clk);
		{wr0_en, wr0_addr, wr0_data} = {1'b1, a0, d0};
		{wr1_en, wr1_addr, wr1_data} = {e1, a1, d1};
		@(negedge core_clk);
		{wr0_en, wr1_en} = 2'b00;
	endtask : wr
	task rd(input logic [2:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		{rd_en, rd_addr} = {1'b1, a};
		@(negedge core_clk);
		rd_en = 1'b0;
		chk({7'h00, rd_valid}, 8'h01);
		chk(rd_data, exp);
	endtask : rd
	task t_rw;
		wr(IDX_CTRL, 8'hFF, 1'b1, 3'h6, 8'hFF);
		chk(ctrl_out, 8'h7F);
		rd(IDX_CTRL, 8'h7F);
		rd(3'h6, 8'h00);
		wr(IDX_CTRL, 8'h2A, 1'b0, IDX_CTRL, 8'h00);
		chk(ctrl_out, 8'h2A);
	endtask : t_rw
	task t_ro;
		{hw_status, hw_state} = {4'hA, 3'h3};
		wr(IDX_STATUS, 8'hFF, 1'b0, 3'h0, 8'h00);
		rd(IDX_STATUS, 8'h3A);
		hw_state = 3'h6;
		rd(IDX_STATUS, 8'h0A);
	endtask : t_ro
	task t_wo;
		wr(IDX_CMD, 8'h3A, 1'b0, 3'h0, 8'h00);
		chk({cmd_out[7:1], cmd_strobe}, 8'h0B);
		rd(IDX_CMD, 8'h00);
		chk({7'h00, cmd_strobe}, 8'h00);
	endtask : t_wo
	task t_sc;
		wr(IDX_FLAG_SET, 8'h0F, 1'b0, 3'h0, 8'h00);
		rd(IDX_FLAG_CLR, 8'h0F);
		rd(IDX_FLAG_SET, 8'h0F);
		wr(IDX_FLAG_CLR, 8'h03, 1'b1, IDX_FLAG_SET, 8'h00);
		chk(flags_out, 8'h0C);
		wr(IDX_FLAG_SET, 8'h05, 1'b1, IDX_FLAG_CLR, 8'h04);
		chk(flags_out, 8'h09);
	endtask : t_sc
	task t_rst;
		wr(IDX_DEBUG, 8'h03, 1'b1, IDX_CTRL, 8'h55);
		soft_reset = 1'b1;
		@(negedge core_clk);
		soft_reset = 1'b0;
		chk({ctrl_out[7:2], debug_out}, 8'h03);
		chk(flags_out | ctrl_out, FLAG_RST);
		chk(cmd_out, CMD_RST);
		reset_n = 1'b0;
		@(negedge core_clk);
		chk({6'h00, debug_out}, {6'h00, DEBUG_RST});
		reset_n = 1'b1;
		rd(IDX_CTRL, CTRL_RST);
	endtask : t_rst
	task wrap_up;
		$display("Checks %0d, errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (3) @(negedge core_clk);
		reset_n = 1'b1;
		t_rw();
		t_ro();
		t_wo();
		t_sc();
		t_rst();
		wrap_up();
	end
endmodule : test_reg_bank
